// >>> logic/isvp_map.svh
// What this block does
// - A row takes 128 clock cycles to read out in parallel mode and 1024 in serial mode.
// - One frame lasts the idle time plus the 2-cycle vertical sync plus the integration time plus the array readout time.
// - A vertical sync pulse lasts at least 2 clock cycles.
// - In serial mode the data-marking pulse on the serial data line lasts exactly one clock cycle.
// - A mode bit selects snapshot operation (set, reset default) or continuous video (cleared).
`ifndef ISVP_MAP_SVH
`define ISVP_MAP_SVH
`define ISVP_CLK_PERIOD_NS 20
`define ISVP_ROW_PAR_CYC 11'h080
`define ISVP_ROW_SER_CYC 11'h400
`define ISVP_HBLANK_CYC 11'h028
`define ISVP_VSYNC_MIN_CYC 11'h002
`define ISVP_ROWS 7'h65
`define ISVP_STEP_NS 10000
`define ISVP_STEP_CYC (`ISVP_STEP_NS / `ISVP_CLK_PERIOD_NS)
`define ISVP_IDLE_MIN 11'h001
`define ISVP_MODE_SNAP_RST 1'b1
`endif

// >>> logic/isvp_pkg.sv
package isvp_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_INTEG = 5'h02,
    ST_VSYNC = 5'h04,
    ST_ROW = 5'h08,
    ST_BLANK = 5'h10
  } isvp_state_e;
  typedef struct packed {
    logic vsync;
    logic hsync;
    logic [7:0] data;
  } isvp_video_s;
endpackage

// >>> logic/isvp_sync3.sv
`timescale 1ns/1ns
// Three-stage pin synchroniser; level changes once stages two and three agree
module isvp_sync3 (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // First stage only feeds the second
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_o <= 1'b0;
    end
    else if (ce_i)
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        q_o <= s3_r;
    end
  end
endmodule

// >>> logic/isvp_video_port.sv
`timescale 1ns/1ns
`include "isvp_map.svh"
// Sensor video port timing: frame sequencer, row readout, serial data line
module isvp_video_port (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic snapshot_mode_i,
  input wire logic serial_mode_i,
  input wire logic [10:0] idle_cnt_i,
  input wire logic [10:0] integ_cnt_i,
  input wire logic vsync_trig_i,
  input wire logic [7:0] pixel_i,
  output isvp_pkg::isvp_video_s video_o,
  output logic ser_d_o,
  output logic idle_o
);
  isvp_pkg::isvp_state_e state_r;
  isvp_pkg::isvp_state_e state_nxt;
  logic [10:0] cyc_r;
  logic [15:0] step_r;
  logic [6:0] row_r;
  logic mode_snap_r;
  logic trig_s;
  logic trig_d_r;
  logic [2:0] bit_r;
  logic [7:0] shift_r;
  logic [10:0] row_run_r;
  logic [10:0] blank_run_r;

  // Trigger pin is asynchronous to the clock
  isvp_sync3 i_isvp_sync3 (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .d_i(vsync_trig_i),
    .q_o(trig_s)
  );

  // Decode of counters and events
  wire trig_rise = trig_s & ~trig_d_r;
  wire step_done = (step_r == 16'(`ISVP_STEP_CYC - 1));
  wire [10:0] idle_eff = (idle_cnt_i < `ISVP_IDLE_MIN) ? `ISVP_IDLE_MIN : idle_cnt_i;
  wire [10:0] row_len = serial_mode_i ? `ISVP_ROW_SER_CYC : `ISVP_ROW_PAR_CYC;
  wire idle_done = step_done && (cyc_r >= idle_eff - 11'h001);
  wire integ_done = step_done && (cyc_r >= integ_cnt_i);
  wire vsync_done = (cyc_r == `ISVP_VSYNC_MIN_CYC - 11'h001);
  wire row_done = (cyc_r == row_len - 11'h001);
  wire blank_done = (cyc_r == `ISVP_HBLANK_CYC - 11'h001);
  wire last_row = (row_r == `ISVP_ROWS - 7'h01);
  // Snapshot waits in idle for a trigger; video runs idle time then starts
  wire start_go = mode_snap_r ? trig_rise : idle_done;
  wire step_run = (state_r == isvp_pkg::ST_IDLE) || (state_r == isvp_pkg::ST_INTEG);

  // Frame sequence: idle, vertical sync, integration, readout rows with blanking
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      isvp_pkg::ST_IDLE:
        if (start_go)
          state_nxt = isvp_pkg::ST_VSYNC;
      isvp_pkg::ST_VSYNC:
        if (vsync_done)
          state_nxt = isvp_pkg::ST_INTEG;
      isvp_pkg::ST_INTEG:
        if (integ_done)
          state_nxt = isvp_pkg::ST_ROW;
      isvp_pkg::ST_ROW:
        if (row_done)
          state_nxt = last_row ? isvp_pkg::ST_IDLE : isvp_pkg::ST_BLANK;
      isvp_pkg::ST_BLANK:
        if (blank_done)
          state_nxt = isvp_pkg::ST_ROW;
      default:
        state_nxt = isvp_pkg::ST_IDLE;
    endcase
  end

  // State, counters and mode latch
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      state_r <= isvp_pkg::ST_IDLE;
      cyc_r <= 11'h000;
      step_r <= 16'h0000;
      row_r <= 7'h00;
      trig_d_r <= 1'b0;
      mode_snap_r <= `ISVP_MODE_SNAP_RST;
    end
    else if (ce_i)
    begin
      trig_d_r <= trig_s;
      state_r <= state_nxt;
      if (state_r == isvp_pkg::ST_IDLE)
        mode_snap_r <= snapshot_mode_i; // Mode changes only between frames
      step_r <= (step_run && !step_done) ? step_r + 16'h0001 : 16'h0000;
      if (state_nxt != state_r)
        cyc_r <= 11'h000;
      else if (!step_run || step_done)
        cyc_r <= cyc_r + 11'h001;
      if (state_r == isvp_pkg::ST_IDLE)
        row_r <= 7'h00;
      else if (state_r == isvp_pkg::ST_ROW && row_done)
        row_r <= row_r + 7'h01;
    end
  end

  // Registered video outputs; data is zero outside active rows
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      video_o <= '0;
    else if (ce_i)
    begin
      video_o.vsync <= (state_nxt == isvp_pkg::ST_VSYNC);
      video_o.hsync <= (state_nxt == isvp_pkg::ST_ROW);
      video_o.data <= (state_nxt == isvp_pkg::ST_ROW && !serial_mode_i) ? pixel_i : 8'h00;
    end
  end

  // Serial line: marker in the first slot of every row, then MSB-first pixel bits
  // Slot zero of each 8-cycle group carries the marker or stays low, so bit zero is dropped
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      ser_d_o <= 1'b0;
      bit_r <= 3'h0;
      shift_r <= 8'h00;
    end
    else if (ce_i)
    begin
      if (serial_mode_i && state_nxt == isvp_pkg::ST_ROW)
      begin
        bit_r <= bit_r + 3'h1;
        if (bit_r == 3'h0)
          shift_r <= pixel_i;
        else
          shift_r <= {shift_r[6:0], 1'b0};
        ser_d_o <= (bit_r == 3'h0) ? (state_r != isvp_pkg::ST_ROW) : shift_r[7];
      end
      else
      begin
        bit_r <= 3'h0;
        ser_d_o <= 1'b0;
      end
    end
  end

  assign idle_o = (state_r == isvp_pkg::ST_IDLE);

  // Assertion helpers: run lengths counted apart from the sequencer's own counter
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      row_run_r <= 11'h000;
      blank_run_r <= 11'h000;
    end
    else if (ce_i)
    begin
      row_run_r <= (state_r == isvp_pkg::ST_ROW) ? row_run_r + 11'h001 : 11'h000;
      blank_run_r <= (state_r == isvp_pkg::ST_BLANK) ? blank_run_r + 11'h001 : 11'h000;
    end
  end

  property p_vsync_min;
    @(posedge ref_clk_i) disable iff (srst_i || !ce_i)
    $rose(video_o.vsync) |=> video_o.vsync;
  endproperty
  a_vsync_min: assert property (p_vsync_min) else $error("vsync shorter than two cycles");

  property p_no_data_blank;
    @(posedge ref_clk_i) disable iff (srst_i)
    !video_o.hsync |-> video_o.data == 8'h00;
  endproperty
  a_no_data_blank: assert property (p_no_data_blank) else $error("pixel data outside active row");

  property p_blank_len;
    @(posedge ref_clk_i) disable iff (srst_i || !ce_i)
    (state_r == isvp_pkg::ST_BLANK && state_nxt != isvp_pkg::ST_BLANK)
      |-> blank_run_r == `ISVP_HBLANK_CYC - 11'h001;
  endproperty
  a_blank_len: assert property (p_blank_len) else $error("blanking not 40 cycles");

  property p_row_par;
    @(posedge ref_clk_i) disable iff (srst_i || !ce_i || serial_mode_i)
    (state_r == isvp_pkg::ST_ROW && cyc_r == 11'h000) |-> ##127 (state_r == isvp_pkg::ST_ROW && row_done);
  endproperty
  a_row_par: assert property (p_row_par) else $error("parallel row not 128 cycles");

  property p_row_ser;
    @(posedge ref_clk_i) disable iff (srst_i || !ce_i)
    (state_r == isvp_pkg::ST_ROW && state_nxt != isvp_pkg::ST_ROW && serial_mode_i)
      |-> row_run_r == `ISVP_ROW_SER_CYC - 11'h001;
  endproperty
  a_row_ser: assert property (p_row_ser) else $error("serial row length wrong");

  property p_trig_idle;
    @(posedge ref_clk_i) disable iff (srst_i || !ce_i)
    $rose(video_o.vsync) |-> $past(state_r) == isvp_pkg::ST_IDLE;
  endproperty
  a_trig_idle: assert property (p_trig_idle) else $error("trigger honoured outside idle");

  property p_reset_snap;
    @(posedge ref_clk_i) srst_i |=> mode_snap_r;
  endproperty
  a_reset_snap: assert property (p_reset_snap) else $error("mode not snapshot after reset");

  property p_idle_floor;
    @(posedge ref_clk_i) disable iff (srst_i)
    idle_eff >= 11'h001;
  endproperty
  a_idle_floor: assert property (p_idle_floor) else $error("idle count below one");

  property p_integ_before_row;
    @(posedge ref_clk_i) disable iff (srst_i || !ce_i)
    (state_r == isvp_pkg::ST_INTEG && state_nxt == isvp_pkg::ST_ROW) |-> step_done;
  endproperty
  a_integ_before_row: assert property (p_integ_before_row) else $error("readout before integration end");

  property p_ser_mark;
    @(posedge ref_clk_i) disable iff (srst_i || !ce_i)
    (serial_mode_i && state_r != isvp_pkg::ST_ROW && state_nxt == isvp_pkg::ST_ROW) |=> ser_d_o;
  endproperty
  a_ser_mark: assert property (p_ser_mark) else $error("no marker pulse at serial row start");
endmodule

// >>> tb/isvp_grabber.sv
`timescale 1ns/1ns
// Capture side: measures sync and serial pulse widths, counts rows and bad pixels
module isvp_grabber (
  input wire logic ref_clk_i,
  input wire isvp_pkg::isvp_video_s video_i,
  input wire logic ser_d_i,
  input wire logic [7:0] pixel_i,
  output logic [15:0] hi_o,
  output logic [15:0] lo_o,
  output logic [15:0] vs_o,
  output logic [15:0] vlo_o,
  output logic [15:0] rows_o,
  output logic [15:0] run_o,
  output logic [15:0] bad_o
);
  logic h_r = 1'b0;
  logic v_r = 1'b0;
  logic s_r = 1'b0;
  logic [15:0] hc_r = 16'h0000;
  logic [15:0] vc_r = 16'h0000;
  logic [15:0] sc_r = 16'h0000;
  logic [15:0] bad_r = 16'h0000;
  // Level changes seen against the previous sample
  wire h_chg = video_i.hsync != h_r;
  wire v_chg = video_i.vsync != v_r;
  wire s_chg = ser_d_i != s_r;
  assign bad_o = bad_r;
  // Runs restart at each change; the finished run is latched, so one sample per run
  always_ff @(posedge ref_clk_i)
  begin
    h_r <= video_i.hsync;
    v_r <= video_i.vsync;
    s_r <= ser_d_i;
    hc_r <= h_chg ? 16'h0001 : hc_r + 16'h0001;
    vc_r <= v_chg ? 16'h0001 : vc_r + 16'h0001;
    sc_r <= s_chg ? 16'h0001 : sc_r + 16'h0001;
    if (h_chg && h_r)
      hi_o <= hc_r;
    if (h_chg && !h_r)
      lo_o <= hc_r;
    if (v_chg && v_r)
      vs_o <= vc_r;
    if (v_chg && !v_r)
      vlo_o <= vc_r;
    if (s_chg && s_r)
      run_o <= sc_r;
    if (v_chg && !v_r)
      rows_o <= 16'h0000;
    else if (h_chg && !h_r)
      rows_o <= rows_o + 16'h0001;
    if (video_i.hsync && video_i.data != pixel_i)
      bad_r <= bad_r + 16'h0001;
  end
endmodule

// >>> tb/isvp_video_port_test.sv
`timescale 1ns/1ns
`include "isvp_map.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module isvp_video_port_test;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic snap = 1'b1;
  logic ser = 1'b0;
  logic trig = 1'b0;
  logic ce = 1'b1;
  logic [10:0] held;
  logic [7:0] pix = 8'hA5;
  logic [10:0] idle_cnt = `ISVP_IDLE_MIN;
  logic [10:0] integ_cnt = 11'h000;
  isvp_pkg::isvp_video_s video;
  logic ser_d;
  logic idle;
  logic [15:0] hi, lo, vs, vlo, rows, run, bad, bad0;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int per;
  int exp_per;
  // Rows: serial mode, pixel, expected row length
  logic [19:0] tbl [2] = '{{1'b0, 8'hA5, `ISVP_ROW_PAR_CYC}, {1'b1, 8'h00, `ISVP_ROW_SER_CYC}};
  isvp_video_port i_isvp_video_port (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce),
    .snapshot_mode_i(snap), .serial_mode_i(ser), .idle_cnt_i(idle_cnt), .integ_cnt_i(integ_cnt),
    .vsync_trig_i(trig), .pixel_i(pix), .video_o(video), .ser_d_o(ser_d), .idle_o(idle));
  isvp_grabber i_isvp_grabber (.ref_clk_i(ref_clk_i), .video_i(video), .ser_d_i(ser_d),
    .pixel_i(pix), .hi_o(hi), .lo_o(lo), .vs_o(vs), .vlo_o(vlo), .rows_o(rows), .run_o(run),
    .bad_o(bad));
  always #10 ref_clk_i = ~ref_clk_i;
  // Hang guard, well above the roughly 45k cycles the run needs
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic pulse_rst();
    srst_i = 1'b1;
    repeat (16) @(negedge ref_clk_i);
    srst_i = 1'b0;
  endtask
  // Held four cycles so the three-flop synchroniser surely sees it
  task automatic fire();
    trig = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    trig = 1'b0;
  endtask
  // Bounded wait: 0 idle, 1 vsync, 2 third row started
  task automatic wait_sig(input int which, input logic lvl, input int lim);
    logic s;
    do
    begin
      @(negedge ref_clk_i);
      s = (which == 0) ? idle : (which == 1) ? video.vsync : (rows == 16'h0003);
      lim--;
    end while (s !== lvl && lim > 0);
  endtask
  initial
  begin
    pulse_rst();
    `CHK({video, ser_d, idle}, 12'h001)
    repeat (2000) @(negedge ref_clk_i);
    `CHK(idle, 1'b1)
    for (int i = 0; i < 2; i++)
    begin
      {ser, pix} = tbl[i][19:11];
      fire();
      wait_sig(1, 1'b1, 2000);
      wait_sig(2, 1'b1, 5000);
      `CHK(hi, {5'h00, tbl[i][10:0]})
      `CHK(lo, {5'h00, `ISVP_HBLANK_CYC})
      `CHK(vs, {5'h00, `ISVP_VSYNC_MIN_CYC})
      if (ser)
        `CHK(run, 16'h0001)
      pulse_rst();
    end
    // Full parallel frame; a second trigger while busy must be ignored
    {ser, pix} = tbl[0][19:11];
    bad0 = bad;
    fire();
    wait_sig(0, 1'b0, 100);
    repeat (600) @(negedge ref_clk_i);
    // Clock enable low mid-row: without the freeze the row would end inside this gap
    ce = 1'b0;
    held = {video, ser_d};
    repeat (50) @(negedge ref_clk_i);
    `CHK({video, ser_d}, held)
    ce = 1'b1;
    fire();
    wait_sig(0, 1'b1, 20000);
    `CHK(rows, 16'h0065)
    `CHK(bad - bad0, 16'h0000)
    repeat (2000) @(negedge ref_clk_i);
    `CHK(idle, 1'b1)
    // Video mode runs free; pipeline slack allowed around the frame sum
    snap = 1'b0;
    integ_cnt = 11'h001;
    exp_per = `ISVP_STEP_CYC * 3 + `ISVP_ROWS * `ISVP_ROW_PAR_CYC + (`ISVP_ROWS - 1) * `ISVP_HBLANK_CYC;
    wait_sig(1, 1'b1, 3000);
    wait_sig(1, 1'b0, 10);
    wait_sig(1, 1'b1, 40000);
    @(negedge ref_clk_i);  // Grabber latches the low run one edge later
    per = vs + vlo;
    `CHK(per >= exp_per - 20 && per <= exp_per + 100, 1'b1)
    summarize();
  end
endmodule
